// ### design/riu_consts.vh
// Summary of operation
// - Only reset and interrupt; reset wins.
// - Reset pin low holds; release starts sequence.
// - Interrupts taken only at instruction boundaries.
// - No detection after flag-register writes.
// - Watchdog reset pulse lasts 518 clocks.
// - Reset sets mask, inits, vectors to zero.
// - All interrupts blocked right after reset.
// - NMI unblocked after first instruction completes.
// - Flag write first keeps everything blocked.
// - Mask flag blocks all but NMI.
// - Four IRQs: falling edge or low level.
// - NMI edge only, edge selectable.
// - Every source has its own vector.
// - IRQ6 from eight individually masked keys.
// - Five external sources, twelve pins, 26 internal.
// - Vector n at address 2n, NMI is 3.
// - Free-running timer uses vectors 19 to 22.
// - Table words 2 to 5 never used.
// - Watchdog raises NMI or overflow interrupt.
// - NMI ignores mask and sets it.
// - NMI edge select: 0 falling, 1 rising.
`ifndef RIU_CONSTS_VH
`define RIU_CONSTS_VH
// Register word indices
`define RIU_OFS_CTRL     3'h0
`define RIU_OFS_SENSE    3'h1
`define RIU_OFS_ENABLE   3'h2
`define RIU_OFS_KEYMASK  3'h3
`define RIU_OFS_STATUS   3'h4
// Control register fields
`define RIU_CTRL_NMIEDGE 0
`define RIU_CTRL_WDT_LO  1
`define RIU_CTRL_WDT_HI  2
// Watchdog actions
`define RIU_WDT_OVFIRQ   2'h0
`define RIU_WDT_NMI      2'h1
`define RIU_WDT_RESET    2'h2
// Reserved bits of sense and enable read as one
`define RIU_IRQ_RSVD     8'hB8
`define RIU_KEYMASK_RST  8'hFF
// Condition flag bit holding the interrupt mask
`define RIU_FLAG_IMASK   7
// Watchdog reset pulse in system clocks
`define RIU_WDT_RST_CYC  10'd518
// Vector numbers and addresses
`define RIU_RESET_VEC    16'h0000
`define RIU_VEC_NMI      6'h03
`define RIU_VEC_IRQ0     6'h04
`define RIU_VEC_IRQ6     6'h0A
`define RIU_VEC_PERIPH   6'h11
`define RIU_VEC_WDT      6'h2C
// Request index positions
`define RIU_IDX_NMI      5'h00
`define RIU_IDX_IRQ6     5'h04
`define RIU_IDX_PERIPH   5'h05
`define RIU_IDX_WDT      5'h19
`define RIU_NREQ         31
// Reset sequencer states
`define RIU_ST_RUN       2'h0
`define RIU_ST_HOLD      2'h1
`define RIU_ST_WDT       2'h2
`define RIU_ST_SEQ       2'h3
`endif

// ### design/riu_sync.v
`timescale 1ns/1ns
`default_nettype none
// Three-stage pin synchroniser; output follows once stages two and three agree
module riu_sync #(
  parameter          W  = 1,
  parameter [W-1:0]  RV = {W{1'b1}}
) (
  input  wire         clk,
  input  wire         rst_n,
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);
  reg [W-1:0] s1;  // Metastability catcher, read only by s2
  reg [W-1:0] s2;  // Second stage
  reg [W-1:0] s3;  // Third stage

  ////////////////////////////////////////////////////////////////////////
  // Shift chain and agreement filter
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= RV;
      s2 <= RV;
      s3 <= RV;
      q  <= RV;
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      // Accept a change only when the last two stages agree
      q  <= (s2 & s3) | (q & (s2 | s3));
    end
  end
endmodule
`default_nettype wire

// ### design/riu_exception_unit.v
`timescale 1ns/1ns
`default_nettype none
`include "riu_consts.vh"
// Reset and interrupt exception unit
module riu_exception_unit (
  input  wire        clk,
  input  wire        rst_n,
  input  wire [4:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output wire        avs_waitrequest,
  input  wire        ext_reset_pin_n,
  input  wire        nmi_pin,
  input  wire [2:0]  irq_pin_n,
  input  wire [7:0]  key_sense_in,
  input  wire        host_in_buf1_full,
  input  wire        host_in_buf2_full,
  input  wire        frt_capture_irq,
  input  wire        frt_compare_a_irq,
  input  wire        frt_compare_b_irq,
  input  wire        frt_overflow_irq,
  input  wire [18:0] periph_irq,
  input  wire        watchdog_overflow_irq,
  input  wire [7:0]  cond_flags_reg,
  input  wire        instr_boundary,
  input  wire        instr_ccr_manip,
  output wire        cpu_hold_reset,
  output reg         periph_init,
  output reg         exc_take,
  output reg  [5:0]  exc_vector,
  output reg  [15:0] exc_vec_addr,
  output reg         exc_set_imask
);

  ////////////////////////////////////////////////////////////////////////
  // Functions

  // Index of the lowest set request bit
  function [4:0] riu_first;
    input [`RIU_NREQ-1:0] r;
    integer k;
    begin
      riu_first = 5'h00;
      for (k = `RIU_NREQ - 1; k >= 0; k = k - 1) begin
        if (r[k]) begin
          riu_first = k[4:0];
        end
      end
    end
  endfunction

  // Vector number of a request index
  function [5:0] riu_vec;
    input [4:0] idx;
    begin
      if (idx == `RIU_IDX_NMI) begin
        riu_vec = `RIU_VEC_NMI;
      end else if (idx < `RIU_IDX_IRQ6) begin
        riu_vec = `RIU_VEC_IRQ0 + {1'b0, idx} - 6'h01;
      end else if (idx == `RIU_IDX_IRQ6) begin
        riu_vec = `RIU_VEC_IRQ6;
      end else if (idx < `RIU_IDX_WDT) begin
        // Vectors 17..36 follow reserved 11..16
        riu_vec = `RIU_VEC_PERIPH + {1'b0, idx} - {1'b0, `RIU_IDX_PERIPH};
      end else begin
        // Vectors 44..49 follow reserved 37..43
        riu_vec = `RIU_VEC_WDT + {1'b0, idx} - {1'b0, `RIU_IDX_WDT};
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  reg  [1:0]  state;              // Reset sequencer state
  reg  [9:0]  wdt_cnt;            // Watchdog reset pulse counter
  reg         reset_cause;        // 1 external pin, 0 watchdog
  reg         block_all;          // All interrupts blocked after reset
  reg         nmi_edge_select;    // 0 falling, 1 rising
  reg  [1:0]  wdt_action;         // Watchdog overflow action
  reg  [3:0]  irq_sense;          // 1 falling edge, 0 low level
  reg  [3:0]  irq_enable;         // Per-request enable
  reg  [7:0]  key_sense_mask_reg; // 1 masks a key input
  reg  [3:0]  irq_pend;           // Latched edge requests
  reg         nmi_pend;           // Latched NMI edge
  reg         wdt_irq_pend;       // Latched watchdog overflow request
  reg         nmi_prev;           // NMI level one cycle ago
  reg  [3:0]  irq_low_prev;       // Request levels one cycle ago
  reg         ack;                // Bus access answered this cycle
  reg  [7:0]  rd_byte;            // Read mux output
  wire [12:0] pins_s;             // Synchronised pins
  wire        ext_rst_s;          // Synchronised reset pin
  wire        nmi_s;              // Synchronised NMI pin
  wire [2:0]  irq_s;              // Synchronised IRQ pins
  wire [7:0]  key_s;              // Synchronised key inputs
  wire        key_low;            // Any unmasked key low
  wire [3:0]  irq_low;            // Active request levels
  wire [3:0]  irq_fall;           // Falling edges of requests
  wire        nmi_edge;           // Selected NMI edge seen
  wire [3:0]  irq_req;            // External maskable requests
  wire [`RIU_NREQ-1:0] req;       // All requests by priority
  wire [`RIU_NREQ-1:0] req_ok;    // Requests after masking
  wire        imask;              // Interrupt mask flag from core
  wire        take_now;           // Exception taken this cycle
  wire [4:0]  take_idx;           // Index being taken
  wire        in_rst;             // Internal reset state
  wire        wdt_rst_req;        // Watchdog reset requested
  wire        bus_acc;            // Read or write pending
  wire        wr_en;              // Write takes effect
  wire [7:0]  sense_rd;           // Sense register image
  wire [7:0]  enable_rd;          // Enable register image

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisation
  riu_sync #(
    .W  (13),
    .RV (13'h1FFF)
  ) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     ({ext_reset_pin_n, nmi_pin, irq_pin_n, key_sense_in}),
    .q     (pins_s)
  );

  assign ext_rst_s = pins_s[12];
  assign nmi_s     = pins_s[11];
  assign irq_s     = pins_s[10:8];
  assign key_s     = pins_s[7:0];

  ////////////////////////////////////////////////////////////////////////
  // Request detection
  assign key_low  = |(~key_s & ~key_sense_mask_reg);
  assign irq_low  = {key_low, ~irq_s};
  assign irq_fall = irq_low & ~irq_low_prev;
  // Rising edge when select is 1, falling when 0
  assign nmi_edge = nmi_edge_select ? (nmi_s & ~nmi_prev)
                                    : (~nmi_s & nmi_prev);
  // Edge mode uses the latch, level mode the live level
  assign irq_req  = (irq_sense & irq_pend) |
                    (~irq_sense & irq_low & irq_enable);

  // Priority order equals vector order; one line per vector
  assign req = {periph_irq[18:14], wdt_irq_pend, periph_irq[13:0],
                frt_overflow_irq, frt_compare_b_irq,
                frt_compare_a_irq, frt_capture_irq,
                host_in_buf2_full, host_in_buf1_full,
                irq_req, nmi_pend};

  assign imask  = cond_flags_reg[`RIU_FLAG_IMASK];
  // Mask flag gates everything except NMI
  assign req_ok = {req[`RIU_NREQ-1:1] & {(`RIU_NREQ-1){~imask}},
                   req[0]};

  // Only at a boundary, not after a flag write, not in reset
  assign take_now = instr_boundary & ~instr_ccr_manip &
                    ~block_all & (state == `RIU_ST_RUN) &
                    (|req_ok);
  assign take_idx = riu_first(req_ok);

  ////////////////////////////////////////////////////////////////////////
  // Reset sequencer
  assign in_rst         = (state == `RIU_ST_HOLD) || (state == `RIU_ST_WDT);
  assign cpu_hold_reset = (state != `RIU_ST_RUN);
  assign wdt_rst_req    = watchdog_overflow_irq &&
                          (wdt_action == `RIU_WDT_RESET);

  // Pin low holds at once; release or pulse end starts the sequence
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state       <= `RIU_ST_SEQ;
      wdt_cnt     <= 10'h000;
      reset_cause <= 1'b1;
    end else if (!ext_rst_s) begin
      // Pin reset overrides every other state
      state       <= `RIU_ST_HOLD;
      reset_cause <= 1'b1;
    end else begin
      case (state)
        `RIU_ST_RUN: begin
          // Watchdog reset stops all processing
          if (wdt_rst_req) begin
            state       <= `RIU_ST_WDT;
            wdt_cnt     <= `RIU_WDT_RST_CYC - 10'd1;
            reset_cause <= 1'b0;
          end
        end
        `RIU_ST_HOLD: begin
          // Pin released high
          state <= `RIU_ST_SEQ;
        end
        `RIU_ST_WDT: begin
          // Internal pulse of exactly 518 cycles
          if (wdt_cnt == 10'h000) begin
            state <= `RIU_ST_SEQ;
          end else begin
            wdt_cnt <= wdt_cnt - 10'd1;
          end
        end
        `RIU_ST_SEQ: begin
          state <= `RIU_ST_RUN;
        end
        default: begin
          state <= `RIU_ST_SEQ;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Exception outputs toward the core
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      periph_init   <= 1'b0;
      exc_take      <= 1'b0;
      exc_vector    <= 6'h00;
      exc_vec_addr  <= 16'h0000;
      exc_set_imask <= 1'b0;
    end else begin
      periph_init   <= (state == `RIU_ST_SEQ) && ext_rst_s;
      exc_take      <= take_now;
      exc_set_imask <= take_now || ((state == `RIU_ST_SEQ) && ext_rst_s);
      if ((state == `RIU_ST_SEQ) && ext_rst_s) begin
        // Reset vector word at address zero
        exc_vector   <= 6'h00;
        exc_vec_addr <= `RIU_RESET_VEC;
      end else if (take_now) begin
        // Entry at twice the vector; words 2..5 never produced
        exc_vector   <= riu_vec(take_idx);
        exc_vec_addr <= {9'h000, riu_vec(take_idx), 1'b0};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Post-reset interrupt blocking
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      block_all <= 1'b1;
    end else if (state != `RIU_ST_RUN) begin
      block_all <= 1'b1;
    end else if (instr_boundary && !instr_ccr_manip) begin
      // First plain instruction done; a flag write keeps the block
      block_all <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pending request latches; a new event wins over a clear
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      nmi_prev     <= 1'b1;
      irq_low_prev <= 4'h0;
      nmi_pend     <= 1'b0;
      wdt_irq_pend <= 1'b0;
      irq_pend     <= 4'h0;
    end else begin
      nmi_prev     <= nmi_s;
      irq_low_prev <= irq_low;
      if (in_rst) begin
        nmi_pend     <= 1'b0;
        wdt_irq_pend <= 1'b0;
        irq_pend     <= 4'h0;
      end else begin
        // NMI from pin edge or from the watchdog
        if (nmi_edge || (watchdog_overflow_irq &&
            wdt_action == `RIU_WDT_NMI)) begin
          nmi_pend <= 1'b1;
        end else if (take_now && take_idx == `RIU_IDX_NMI) begin
          nmi_pend <= 1'b0;
        end
        // Watchdog overflow interrupt
        if (watchdog_overflow_irq && wdt_action == `RIU_WDT_OVFIRQ) begin
          wdt_irq_pend <= 1'b1;
        end else if (take_now && take_idx == `RIU_IDX_WDT) begin
          wdt_irq_pend <= 1'b0;
        end
        irq_pend <= next_irq_pend(irq_pend);
      end
    end
  end

  // Edge latch update for the four external requests
  function [3:0] next_irq_pend;
    input [3:0] cur;
    integer j;
    begin
      next_irq_pend = cur;
      for (j = 0; j < 4; j = j + 1) begin
        if (irq_sense[j] && irq_enable[j] && irq_fall[j]) begin
          next_irq_pend[j] = 1'b1;
        end else if (take_now && take_idx == j[4:0] + 5'h01) begin
          next_irq_pend[j] = 1'b0;
        end else if (imask && !irq_sense[j] && !irq_enable[j]) begin
          next_irq_pend[j] = 1'b0;
        end
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave: one wait state per access
  assign bus_acc         = avs_read | avs_write;
  assign avs_waitrequest = bus_acc & ~ack;
  assign wr_en           = avs_write & ack & avs_byteenable[0];

  assign sense_rd  = `RIU_IRQ_RSVD | {1'b0, irq_sense[3], 3'h0, irq_sense[2:0]};
  assign enable_rd = `RIU_IRQ_RSVD | {1'b0, irq_enable[3], 3'h0, irq_enable[2:0]};

  // Read mux; unmapped words read zero
  always @* begin
    case (avs_address[4:2])
      `RIU_OFS_CTRL:    rd_byte = {5'h00, wdt_action, nmi_edge_select};
      `RIU_OFS_SENSE:   rd_byte = sense_rd;
      `RIU_OFS_ENABLE:  rd_byte = enable_rd;
      `RIU_OFS_KEYMASK: rd_byte = key_sense_mask_reg;
      `RIU_OFS_STATUS:  rd_byte = {nmi_pend, wdt_irq_pend, irq_pend,
                                   block_all, reset_cause};
      default:          rd_byte = 8'h00;
    endcase
  end

  // Access handshake and read data
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack          <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      ack <= bus_acc & ~ack;
      if (avs_read && !ack) begin
        avs_readdata <= {24'h00_0000, rd_byte};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Software registers; reinitialised by every internal reset
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      nmi_edge_select    <= 1'b0;
      wdt_action         <= `RIU_WDT_OVFIRQ;
      irq_sense          <= 4'h0;
      irq_enable         <= 4'h0;
      key_sense_mask_reg <= `RIU_KEYMASK_RST;
    end else if (in_rst) begin
      nmi_edge_select    <= 1'b0;
      wdt_action         <= `RIU_WDT_OVFIRQ;
      irq_sense          <= 4'h0;
      irq_enable         <= 4'h0;
      key_sense_mask_reg <= `RIU_KEYMASK_RST;
    end else if (wr_en) begin
      case (avs_address[4:2])
        `RIU_OFS_CTRL: begin
          nmi_edge_select <= avs_writedata[`RIU_CTRL_NMIEDGE];
          wdt_action      <= avs_writedata[`RIU_CTRL_WDT_HI:`RIU_CTRL_WDT_LO];
        end
        `RIU_OFS_SENSE: begin
          irq_sense <= {avs_writedata[6], avs_writedata[2:0]};
        end
        `RIU_OFS_ENABLE: begin
          irq_enable <= {avs_writedata[6], avs_writedata[2:0]};
        end
        `RIU_OFS_KEYMASK: begin
          key_sense_mask_reg <= avs_writedata[7:0];
        end
        default: begin
          // Status and unmapped words ignore writes
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ### verif/riu_checker.sv
`timescale 1ns/1ns
`default_nettype none
// Watches the core-facing side of the exception unit
module riu_checker (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        ext_reset_pin_n,
  input wire logic        watchdog_overflow_irq,
  input wire logic [7:0]  cond_flags_reg,
  input wire logic        instr_boundary,
  input wire logic        instr_ccr_manip,
  input wire logic        cpu_hold_reset,
  input wire logic        periph_init,
  input wire logic        exc_take,
  input wire logic [5:0]  exc_vector,
  input wire logic [15:0] exc_vec_addr,
  input wire logic        exc_set_imask
);
  logic [9:0] hold_cnt;   // Cycles spent in reset so far
  logic       wdt_entry;  // Reset was entered from a watchdog pulse
  logic       fresh;      // No plain instruction has finished since reset
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////
  // Length and cause of the current reset stay
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_cnt  <= 10'h000;
      wdt_entry <= 1'b0;
      fresh     <= 1'b1;
    end else begin
      hold_cnt  <= cpu_hold_reset ? hold_cnt + 10'h001 : 10'h000;
      wdt_entry <= cpu_hold_reset ? wdt_entry : watchdog_overflow_irq;
      if (cpu_hold_reset) begin
        fresh <= 1'b1;
      end else if (instr_boundary && !instr_ccr_manip) begin
        fresh <= 1'b0;
      end
    end
  end
  ////////////////////////////////////////////////////////////////
  // Multi-step reset behaviour
  sequence s_pin_low;
    !ext_reset_pin_n [*8];
  endsequence
  sequence s_leave;
    $fell(cpu_hold_reset);
  endsequence
  property p_pin_hold;
    s_pin_low |-> cpu_hold_reset;
  endproperty
  a_pin_hold: assert property (p_pin_hold) else $error("pin low but core not held");
  property p_wdt_len;
    s_leave ##0 wdt_entry |-> hold_cnt == 10'd519;
  endproperty
  a_wdt_len: assert property (p_wdt_len) else $error("watchdog reset length wrong");
  property p_init;
    s_leave |-> periph_init && exc_set_imask;
  endproperty
  a_init: assert property (p_init) else $error("no init pulse after reset");
  property p_block;
    fresh && instr_boundary |=> !exc_take;
  endproperty
  a_block: assert property (p_block) else $error("take before first instruction");
  ////////////////////////////////////////////////////////////////
  // Interrupt acceptance
  property p_addr;
    exc_take |-> exc_vec_addr == {9'h000, exc_vector, 1'b0};
  endproperty
  a_addr: assert property (p_addr) else $error("vector address not twice number");
  property p_cause;
    exc_take |-> $past(instr_boundary) && !$past(instr_ccr_manip) && exc_set_imask;
  endproperty
  a_cause: assert property (p_cause) else $error("take without clean boundary");
  property p_mask;
    exc_take && exc_vector != 6'h03 |-> !$past(cond_flags_reg[7]);
  endproperty
  a_mask: assert property (p_mask) else $error("masked request taken");
  property p_hold_no_take;
    $past(cpu_hold_reset) |-> !exc_take;
  endproperty
  a_hold_no_take: assert property (p_hold_no_take) else $error("take during reset");
  property p_legal;
    exc_take |-> exc_vector inside {[3:6], 10, [17:36], [44:49]};
  endproperty
  a_legal: assert property (p_legal) else $error("reserved vector taken");
endmodule
`default_nettype wire

// ### verif/riu_core_model.sv
`timescale 1ns/1ns
`default_nettype none
// Core stand-in: four-cycle instructions, owns the mask flag
module riu_core_model (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       cpu_hold_reset,
  input  wire logic       exc_set_imask,
  input  wire logic       mask_clr,
  input  wire logic       manip_req,
  output var  logic       instr_boundary,
  output var  logic       instr_ccr_manip,
  output var  logic [7:0] cond_flags_reg
);
  logic [1:0] phase;  // Position inside the current instruction
  // Boundary pulse ends each instruction; first one stands for stack setup
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase           <= 2'h0;
      instr_boundary  <= 1'b0;
      instr_ccr_manip <= 1'b0;
    end else begin
      phase           <= cpu_hold_reset ? 2'h0 : phase + 2'h1;
      instr_boundary  <= !cpu_hold_reset && (phase == 2'h3);
      instr_ccr_manip <= !cpu_hold_reset && (phase == 2'h3) && manip_req;
    end
  end
  // Mask set by exception entry, cleared when software asks
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cond_flags_reg <= 8'h80;
    end else if (exc_set_imask) begin
      cond_flags_reg[7] <= 1'b1;
    end else if (mask_clr) begin
      cond_flags_reg[7] <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### verif/riu_exception_unit_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "riu_consts.vh"
module riu_exception_unit_tb;
  logic        clk, rst_n, rd, wr, ext_n, nmi, wdt, hold, pinit, take, simask;
  logic        wreq, bnd, manip, mask_clr, manip_req;
  logic [4:0]  addr;
  logic [31:0] wdata, rdata;
  logic [2:0]  irq_n;
  logic [7:0]  keys, flags;
  logic [24:0] lvl;      // Level sources in vector order from 17
  logic [5:0]  vec;
  logic [15:0] vaddr;
  int          checked, mismatches, cycles;
  riu_exception_unit uut (.clk, .rst_n, .avs_address(addr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wdata), .avs_byteenable(4'hF), .avs_readdata(rdata),
    .avs_waitrequest(wreq), .ext_reset_pin_n(ext_n), .nmi_pin(nmi), .irq_pin_n(irq_n),
    .key_sense_in(keys), .host_in_buf1_full(lvl[0]), .host_in_buf2_full(lvl[1]),
    .frt_capture_irq(lvl[2]), .frt_compare_a_irq(lvl[3]), .frt_compare_b_irq(lvl[4]),
    .frt_overflow_irq(lvl[5]), .periph_irq(lvl[24:6]), .watchdog_overflow_irq(wdt),
    .cond_flags_reg(flags), .instr_boundary(bnd), .instr_ccr_manip(manip),
    .cpu_hold_reset(hold), .periph_init(pinit), .exc_take(take), .exc_vector(vec),
    .exc_vec_addr(vaddr), .exc_set_imask(simask));
  riu_core_model u_core (.clk, .rst_n, .cpu_hold_reset(hold),
    .exc_set_imask(simask), .mask_clr(mask_clr), .manip_req(manip_req),
    .instr_boundary(bnd), .instr_ccr_manip(manip), .cond_flags_reg(flags));
  ////////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      complete_run;
    end
  end
  ////////////////////////////////////////////////////////////////
  // Shared helpers
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] v,
                     output logic [7:0] q);
    addr  <= a;
    wdata <= {24'h000000, v};
    rd    <= !w;
    wr    <= w;
    @(posedge clk iff (wreq === 1'b0));
    q = rdata[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wreg(input logic [4:0] a, input logic [7:0] v);
    logic [7:0] q;
    bus(1'b1, a, v, q);
  endtask
  task automatic rreg(input string n, input logic [4:0] a, input logic [7:0] e,
                      input logic [7:0] m = 8'hFF);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(n, {8'h00, e & m}, {8'h00, q & m});
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic unmask;
    mask_clr <= 1'b1;
    @(posedge clk);
    mask_clr <= 1'b0;
  endtask
  task automatic pulse_wdt;
    wdt <= 1'b1;
    @(posedge clk);
    wdt <= 1'b0;
  endtask
  task automatic expect_take(input logic [5:0] v);
    int k = 0;
    while (take !== 1'b1 && k < 60) begin
      @(posedge clk);
      k++;
    end
    chk("take", 16'h0001, {15'h0000, take});
    chk("vector", {10'h000, v}, {10'h000, vec});
    chk("address", {9'h000, v, 1'b0}, vaddr);
  endtask
  task automatic no_take(input int n);
    logic seen = 1'b0;
    repeat (n) begin
      @(posedge clk);
      seen = seen | (take === 1'b1);
    end
    chk("no take", 16'h0000, {15'h0000, seen});
  endtask
  // Times a reset stay and checks the init pulse
  task automatic leave_hold(input logic [15:0] e);
    int n = 0;
    while (hold !== 1'b1 && n < 30) begin
      @(posedge clk);
      n++;
    end
    n = 0;
    while (hold === 1'b1 && n < 600) begin
      @(posedge clk);
      n++;
    end
    chk("hold length", e, n[15:0]);
    chk("init pulse", 16'h0001, {15'h0000, pinit});
    step(2);
    chk("reset vector", 16'h0000, vaddr);
  endtask
  ////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_regs;
    rreg("ctrl", 5'h00, 8'h00);
    rreg("sense", 5'h04, 8'hB8);
    rreg("enable", 5'h08, 8'hB8);
    rreg("keymask", 5'h0C, 8'hFF);
    rreg("unmapped", 5'h14, 8'h00);
  endtask
  task automatic t_nmi;
    wreg(5'h00, 8'h01);
    rreg("ctrl", 5'h00, 8'h01);
    nmi <= 1'b0;
    no_take(30);
    nmi <= 1'b1;
    expect_take(6'h03);
    wreg(5'h00, 8'h00);
    nmi <= 1'b0;
    expect_take(6'h03);
    nmi <= 1'b1;
    no_take(30);
  endtask
  task automatic t_wdt_irq;
    wreg(5'h00, 8'h02);
    pulse_wdt;
    expect_take(6'h03);
    wreg(5'h00, 8'h00);
    unmask;
    pulse_wdt;
    expect_take(6'h2C);
  endtask
  task automatic t_levels;
    for (int i = 0; i < 25; i++) begin
      lvl[i] <= 1'b1;
      unmask;
      expect_take(i < 20 ? 6'(17 + i) : 6'(25 + i));
      lvl[i] <= 1'b0;
      @(posedge clk);
    end
  endtask
  task automatic t_prio;
    wreg(5'h08, 8'h03);
    irq_n[0] <= 1'b0;
    lvl[2]   <= 1'b1;
    step(8);
    unmask;
    expect_take(6'h04);
    irq_n[0] <= 1'b1;
    step(8);
    unmask;
    expect_take(6'h13);
    lvl[2] <= 1'b0;
    lvl[5] <= 1'b1;
    no_take(30);
    unmask;
    expect_take(6'h16);
    lvl[5] <= 1'b0;
  endtask
  task automatic t_flag_write;
    manip_req <= 1'b1;
    lvl[3]    <= 1'b1;
    unmask;
    no_take(30);
    manip_req <= 1'b0;
    expect_take(6'h14);
    lvl[3] <= 1'b0;
  endtask
  task automatic t_edge;
    wreg(5'h04, 8'h02);
    wreg(5'h08, 8'h02);
    irq_n[1] <= 1'b0;
    step(3);
    irq_n[1] <= 1'b1;
    step(10);
    unmask;
    expect_take(6'h05);
    unmask;
    no_take(30);
  endtask
  task automatic t_keys;
    wreg(5'h0C, 8'hFD);
    wreg(5'h08, 8'h40);
    keys <= 8'hFE;
    no_take(30);
    keys <= 8'hFC;
    expect_take(6'h0A);
    keys <= 8'hFF;
  endtask
  task automatic t_wdt_reset;
    wreg(5'h00, 8'h04);
    pulse_wdt;
    leave_hold(16'd519);
    rreg("ctrl", 5'h00, 8'h00);
    rreg("cause", 5'h10, 8'h00, 8'h01);
  endtask
  task automatic t_pin;
    ext_n <= 1'b0;
    step(12);
    chk("held", 16'h0001, {15'h0000, hold});
    ext_n <= 1'b1;
    leave_hold(16'h0007);
    rreg("cause", 5'h10, 8'h01, 8'h01);
  endtask
  task automatic complete_run;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {rst_n, rd, wr, wdt, mask_clr, manip_req} = '0;
    {addr, wdata, lvl} = '0;
    {ext_n, nmi, irq_n, keys} = '1;
    step(16);
    rst_n <= 1'b1;
    step(2);
    t_regs;
    t_nmi;
    t_wdt_irq;
    t_levels;
    t_prio;
    t_flag_write;
    t_edge;
    t_keys;
    t_wdt_reset;
    t_pin;
    complete_run;
  end
endmodule
bind riu_exception_unit riu_checker u_chk (.clk, .rst_n, .ext_reset_pin_n,
  .watchdog_overflow_irq, .cond_flags_reg, .instr_boundary, .instr_ccr_manip,
  .cpu_hold_reset, .periph_init, .exc_take, .exc_vector, .exc_vec_addr, .exc_set_imask);
`default_nettype wire
